// ===== src/spc_pkg.sv
// Package of register addresses, field positions, reset values and types for the serial port.
package spc_pkg;
   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CFG = 8'h9A;
   localparam logic [7:0] ADDR_DAT = 8'h9B;
   localparam logic [7:0] ADDR_DIV = 8'h9D;
   localparam logic [7:0] ADDR_CTL = 8'hF8;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_CFG = 8'h07;
   localparam logic [7:0] RST_DIV = 8'h00;
   localparam logic [7:0] RST_CTL = 8'h06;
   // ----------------------------------------------------------------
   // Configuration field positions
   // ----------------------------------------------------------------
   localparam int CFG_BUSY   = 7;
   localparam int CFG_MASTER = 6;
   localparam int CFG_PHASE  = 5;
   localparam int CFG_POL    = 4;
   // ----------------------------------------------------------------
   // Control field positions
   // ----------------------------------------------------------------
   localparam int CTL_DONE   = 7;
   localparam int CTL_WRITE_COLLISION_FLAG   = 6;
   localparam int CTL_MODE_FAULT_FLAG   = 5;
   localparam int CTL_OVR    = 4;
   localparam int CTL_SSM_HI = 3;
   localparam int CTL_SSM_LO = 2;
   localparam int CTL_EN     = 0;
   // ----------------------------------------------------------------
   // Slave-select modes and timing
   // ----------------------------------------------------------------
   localparam logic [1:0] SSM_3WIRE = 2'h0;
   localparam logic [1:0] SSM_4WIRE = 2'h1;
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [3:0] LAST_HALF = 4'hF;
   localparam logic [1:0] DEGLITCH_CYC = 2'h2;
   typedef enum logic {MST_IDLE, MST_RUN} spc_mst_e;
endpackage : spc_pkg

// ===== src/spc_sync.sv
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module spc_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= pin_in;
         sync_out <= meta_q;
      end
   end
endmodule : spc_sync
`default_nettype wire

// ===== src/spc_buf2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module spc_buf2 (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       flush,
   input  wire logic [7:0] in_data,
   input  wire logic       in_valid,
   output logic            in_ready,
   output logic      [7:0] out_data,
   output logic            out_valid,
   input  wire logic       out_ready
);
   logic [7:0] mem_q [2];
   logic       wp_q;
   logic       rp_q;
   logic [1:0] cnt_q;
   logic       push;
   logic       pop;

   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[rp_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_ff @(posedge mclk) begin
      if (!rst_n || flush) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            wp_q <= ~wp_q;
         end
         if (pop) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mem_q[0] <= 8'h00;
         mem_q[1] <= 8'h00;
      end else if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end
endmodule : spc_buf2
`default_nettype wire

// ===== src/spc_port.sv
// Serial port with configuration, control, clock-rate and data registers.
`timescale 1ns/1ps
`default_nettype none
module spc_port (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic            event_req,
   input  wire logic       sck_i,
   output logic            sck_o,
   output logic            sck_oe,
   input  wire logic       mosi_i,
   output logic            mosi_o,
   output logic            mosi_oe,
   input  wire logic       miso_i,
   output logic            miso_o,
   output logic            miso_oe,
   input  wire logic       slave_select_i,
   output logic            slave_select_o,
   output logic            slave_select_oe
);
   // ----------------------------------------------------------------
   // Register state and pin inputs
   // ----------------------------------------------------------------
   logic             master_enable_q, clock_phase_q, clock_polarity_q, port_enable_q;
   logic [1:0]       ssm_q;
   logic [7:0]       clock_divider_value_q;
   logic [3:0]       flag_q;
   logic [7:0]       tx_buf_q, tx_sh_q, rx_sh_q;
   logic             tx_buffer_empty_q, shift_reg_empty_q;
   spc_pkg::spc_mst_e mst_q;
   logic [7:0]       div_cnt_q;
   logic [3:0]       half_q;
   logic [2:0]       bit_cnt_q;
   logic             sck_p_q, sel_n_q, sel_p_q;
   logic [1:0]       glitch_q;
   logic [3:0]       pins_s;
   logic             sck_s, mosi_s, miso_s, nss_s;
   logic             mst_run, div_last, mst_start, mst_done, busy;
   logic             slv_act, lead, trail, samp, shft, slv_done, slv_load, sel;
   logic             wr_dat, wr_ctl, coll, mode_fault_flag_evt, ovr_evt, byte_done;
   logic             rx_ready, rx_valid, rx_pop, msamp_q, mdone_q;
   logic [7:0]       rx_data;

   spc_sync #(.W(4)) u_sync (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .pin_in   ({sck_i, mosi_i, miso_i, !slave_select_i}),
      .sync_out (pins_s)
   );
   // Select travels inverted so that the synchroniser resets to the idle high level.
   assign {sck_s, mosi_s, miso_s} = pins_s[3:1];
   assign nss_s                   = !pins_s[0];

   // ----------------------------------------------------------------
   // Shared decode
   // ----------------------------------------------------------------
   assign wr_dat    = sfr_wr && (sfr_addr == spc_pkg::ADDR_DAT);
   assign wr_ctl    = sfr_wr && (sfr_addr == spc_pkg::ADDR_CTL);
   assign rx_pop    = sfr_rd && (sfr_addr == spc_pkg::ADDR_DAT);
   assign mst_run   = (mst_q == spc_pkg::MST_RUN);
   assign div_last  = mst_run && (div_cnt_q == clock_divider_value_q);
   assign mst_start = port_enable_q && master_enable_q && !mst_run && !tx_buffer_empty_q;
   assign mst_done  = div_last && (half_q == spc_pkg::LAST_HALF);
   assign sel       = !sel_n_q;
   assign slv_act   = port_enable_q && !master_enable_q &&
                      ((ssm_q != spc_pkg::SSM_4WIRE) || sel);
   assign lead      = (sck_s != clock_polarity_q) && (sck_p_q == clock_polarity_q);
   assign trail     = (sck_s == clock_polarity_q) && (sck_p_q != clock_polarity_q);
   assign samp      = slv_act && (clock_phase_q ? trail : lead);
   assign shft      = slv_act && (clock_phase_q ? lead : trail) && (bit_cnt_q != 3'h0);
   assign slv_done  = samp && (bit_cnt_q == spc_pkg::LAST_BIT);
   assign slv_load  = slv_act && !tx_buffer_empty_q && (shift_reg_empty_q || slv_done);
   assign busy      = mst_run || (slv_act && (bit_cnt_q != 3'h0));
   assign coll      = wr_dat && (!tx_buffer_empty_q || busy);
   assign mode_fault_flag_evt  = master_enable_q && sel && (ssm_q == spc_pkg::SSM_4WIRE);
   assign byte_done = mst_done || slv_done;
   assign ovr_evt   = slv_done && !rx_ready;
   assign event_req = |flag_q;

   // ----------------------------------------------------------------
   // Configuration, divider and control registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         master_enable_q  <= spc_pkg::RST_CFG[spc_pkg::CFG_MASTER];
         clock_phase_q    <= spc_pkg::RST_CFG[spc_pkg::CFG_PHASE];
         clock_polarity_q <= spc_pkg::RST_CFG[spc_pkg::CFG_POL];
      end else if (mode_fault_flag_evt) begin
         master_enable_q <= 1'b0;
      end else if (sfr_wr && (sfr_addr == spc_pkg::ADDR_CFG)) begin
         master_enable_q  <= sfr_wdata[spc_pkg::CFG_MASTER];
         clock_phase_q    <= sfr_wdata[spc_pkg::CFG_PHASE];
         clock_polarity_q <= sfr_wdata[spc_pkg::CFG_POL];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         clock_divider_value_q <= spc_pkg::RST_DIV;
      end else if (sfr_wr && (sfr_addr == spc_pkg::ADDR_DIV)) begin
         clock_divider_value_q <= sfr_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ssm_q         <= spc_pkg::RST_CTL[spc_pkg::CTL_SSM_HI:spc_pkg::CTL_SSM_LO];
         port_enable_q <= spc_pkg::RST_CTL[spc_pkg::CTL_EN];
      end else begin
         if (wr_ctl) begin
            ssm_q         <= sfr_wdata[spc_pkg::CTL_SSM_HI:spc_pkg::CTL_SSM_LO];
            port_enable_q <= sfr_wdata[spc_pkg::CTL_EN];
         end
         if (mode_fault_flag_evt) begin
            port_enable_q <= 1'b0;
         end
      end
   end

   // Event flags in order done, collision, fault, overrun; set beats clear.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         flag_q <= spc_pkg::RST_CTL[spc_pkg::CTL_DONE:spc_pkg::CTL_OVR];
      end else begin
         flag_q <= {byte_done, coll, mode_fault_flag_evt, ovr_evt} |
                   (flag_q & ~({4{wr_ctl}} &
                   ~sfr_wdata[spc_pkg::CTL_DONE:spc_pkg::CTL_OVR]));
      end
   end

   // ----------------------------------------------------------------
   // Transmit buffer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_buf_q          <= 8'h00;
         tx_buffer_empty_q <= spc_pkg::RST_CTL[1];
      end else if (wr_dat && !coll) begin
         tx_buf_q          <= sfr_wdata;
         tx_buffer_empty_q <= 1'b0;
      end else if (mst_start || slv_load) begin
         tx_buffer_empty_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Master sequencer and clock divider
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mst_q <= spc_pkg::MST_IDLE;
      end else begin
         case (mst_q)
            spc_pkg::MST_IDLE: begin
               if (mst_start) begin
                  mst_q <= spc_pkg::MST_RUN;
               end
            end
            spc_pkg::MST_RUN: begin
               if (mst_done || !port_enable_q || !master_enable_q) begin
                  mst_q <= spc_pkg::MST_IDLE;
               end
            end
            default: begin
               mst_q <= spc_pkg::MST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || !mst_run) begin
         div_cnt_q <= 8'h00;
         half_q    <= 4'h0;
      end else if (div_last) begin
         div_cnt_q <= 8'h00;
         half_q    <= half_q + 4'h1;
      end else begin
         div_cnt_q <= div_cnt_q + 8'h01;
      end
   end

   // Master capture runs one cycle late so it sees the pin one cycle before the bit ends.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         msamp_q <= 1'b0;
         mdone_q <= 1'b0;
      end else begin
         msamp_q <= div_last && half_q[0];
         mdone_q <= mst_done;
      end
   end

   // ----------------------------------------------------------------
   // Shift registers for both modes
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tx_sh_q <= 8'h00;
         rx_sh_q <= 8'h00;
      end else begin
         if (mst_start || slv_load) begin
            tx_sh_q <= tx_buf_q;
         end else if ((div_last && half_q[0]) || shft) begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
         end
         if (msamp_q) begin
            rx_sh_q <= {rx_sh_q[6:0], miso_s};
         end else if (samp) begin
            rx_sh_q <= {rx_sh_q[6:0], mosi_s};
         end
      end
   end

   // ----------------------------------------------------------------
   // Slave bit counter, select filter and shift-empty flag
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sck_p_q   <= 1'b0;
         bit_cnt_q <= 3'h0;
      end else begin
         sck_p_q <= sck_s;
         if (!slv_act || ((ssm_q == spc_pkg::SSM_4WIRE) && sel && !sel_p_q)) begin
            bit_cnt_q <= 3'h0;
         end else if (samp) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sel_n_q  <= 1'b1;
         sel_p_q  <= 1'b0;
         glitch_q <= 2'h0;
      end else begin
         sel_p_q <= sel;
         if (nss_s == sel_n_q) begin
            glitch_q <= 2'h0;
         end else if (glitch_q == spc_pkg::DEGLITCH_CYC - 2'h1) begin
            sel_n_q  <= nss_s;
            glitch_q <= 2'h0;
         end else begin
            glitch_q <= glitch_q + 2'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || !slv_act) begin
         shift_reg_empty_q <= 1'b1;
      end else if (slv_load || (lead || trail)) begin
         shift_reg_empty_q <= slv_done && !slv_load;
      end
   end

   // ----------------------------------------------------------------
   // Receive buffer and register reads
   // ----------------------------------------------------------------
   spc_buf2 u_rxbuf (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .flush     (!port_enable_q),
      .in_data   ({rx_sh_q[6:0], slv_done ? mosi_s : miso_s}),
      .in_valid  (slv_done || mdone_q),
      .in_ready  (rx_ready),
      .out_data  (rx_data),
      .out_valid (rx_valid),
      .out_ready (rx_pop)
   );

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            spc_pkg::ADDR_CFG: sfr_rdata <= {busy, master_enable_q,
               clock_phase_q, clock_polarity_q, sel, nss_s,
               shift_reg_empty_q || master_enable_q,
               !rx_valid || master_enable_q};
            spc_pkg::ADDR_CTL: sfr_rdata <= {flag_q, ssm_q, tx_buffer_empty_q,
               port_enable_q};
            spc_pkg::ADDR_DIV: sfr_rdata <= clock_divider_value_q;
            spc_pkg::ADDR_DAT: sfr_rdata <= rx_data;
            default:           sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   assign sck_o  = clock_polarity_q ^
                   (mst_run && (clock_phase_q ? !half_q[0] : half_q[0]));
   assign sck_oe = port_enable_q && master_enable_q;
   assign mosi_o  = tx_sh_q[7];
   assign mosi_oe = port_enable_q && master_enable_q;
   assign miso_o  = tx_sh_q[7];
   assign miso_oe = slv_act;
   assign slave_select_o  = ssm_q[0];
   assign slave_select_oe = ssm_q[1];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_busy_master: assert property (mst_run && sfr_rd &&
      sfr_addr == spc_pkg::ADDR_CFG |=> sfr_rdata[spc_pkg::CFG_BUSY])
      else $error("Busy low during master run.");
   a_sck_idle: assert property (!mst_run |-> sck_o == clock_polarity_q)
      else $error("Serial clock not at idle level.");
   a_sck_toggle: assert property (div_last && half_q != spc_pkg::LAST_HALF |=>
      $changed(sck_o)) else $error("Serial clock did not toggle at divider end.");
   a_div_hold: assert property (mst_run && !div_last && !$changed(clock_divider_value_q)
      |=> !mst_run || $stable(sck_o)) else $error("Clock moved mid half period.");
   a_done_flag: assert property (byte_done |=> flag_q[3])
      else $error("Done flag not set.");
   a_write_collision_flag_keep: assert property (coll |=> flag_q[2] && $stable(tx_buf_q))
      else $error("Collision write not discarded.");
   a_mode_fault_flag_off: assert property (mode_fault_flag_evt |=> flag_q[1] && !master_enable_q &&
      !port_enable_q) else $error("Mode fault did not disable port.");
   a_ovr_set: assert property (ovr_evt |=> flag_q[0])
      else $error("Overrun flag not set.");
   a_tx_fill: assert property (wr_dat && !coll |=> !tx_buffer_empty_q)
      else $error("Transmit empty not cleared.");
   a_sel_out: assert property (ssm_q[1] |-> slave_select_oe &&
      slave_select_o == ssm_q[0]) else $error("Select output wrong.");

   c_master_byte: cover property (mst_done);
   c_slave_byte:  cover property (slv_done);
   c_mode_fault:  cover property (mode_fault_flag_evt);
   c_overrun:     cover property (ovr_evt);
endmodule : spc_port
`default_nettype wire

// ===== tb/spc_slave_model.sv
// Behavioural model of the external serial slave device.
`timescale 1ns/1ps
`default_nettype none
module spc_slave_model (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic       arm,
   input  wire logic       slow,
   input  wire logic [7:0] tx,
   output logic            miso,
   output logic      [7:0] rx
);
   int  nl;
   int  nt;
   int  idx;
   wire m0;
   wire m1;
   // Leading edges sample in phase 0, trailing edges in phase 1.
   always @(posedge arm or sck) begin
      if (arm) begin
         nl = 0;
         nt = 0;
      end else if (sck ^ cpol) begin
         nl = nl + 1;
         if (!cpha) rx = {rx[6:0], mosi};
      end else begin
         nt = nt + 1;
         if (cpha) rx = {rx[6:0], mosi};
      end
   end
   // Before a frame in phase 1 the line shows the inverse of its first bit, after a frame in phase 0 the inverse of the bit it last carried.
   assign idx = cpha ? nl - 1 : nt;
   assign m0 = (idx < 0) ? ~tx[7] : (idx > 7) ? ~tx[0] : tx[7 - idx];
   assign #15 m1 = m0;
   assign miso = slow ? m1 : m0;
endmodule : spc_slave_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking testbench for the serial port block.
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ----------------------------------------------------------------
   // Signals, design and far-side model
   // ----------------------------------------------------------------
   logic       mclk, rst_n, sfr_wr, sfr_rd, event_req, sck_o, sck_oe, mosi_o, mosi_oe, miso_i;
   logic       miso_o, miso_oe, ss_o, ss_oe, sck_m, mosi_m, ss_m, sck_w, ss_w, ckq;
   logic       cpol, cpha, arm, slow;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, stx, srx, v, d, dv, so, t;
   int         num_errors = 0;
   int         tests_run = 0;
   int         tog = 0;
   int         gap = 0;
   assign sck_w = sck_oe ? sck_o : sck_m;
   assign ss_w = ss_oe ? ss_o : ss_m;
   spc_port dut (
      .mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .event_req(event_req), .sck_i(sck_w),
      .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_m), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
      .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe), .slave_select_i(ss_w),
      .slave_select_o(ss_o), .slave_select_oe(ss_oe)
   );
   spc_slave_model sm (.sck(sck_w), .mosi(mosi_o), .cpol(cpol), .cpha(cpha), .arm(arm),
      .slow(slow), .tx(stx), .miso(miso_i), .rx(srx));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ----------------------------------------------------------------
   // Tasks and functions
   // ----------------------------------------------------------------
   function automatic logic [7:0] cfg_exp(input logic m, ph, po);
      return {1'b0, m, ph, po, 4'h7};
   endfunction : cfg_exp
   function automatic logic [7:0] half(input logic [7:0] x);
      return x + 8'h01;
   endfunction : half
   task automatic chk(input string n, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [7:0] a, wd);
      sfr_addr = a;
      sfr_wdata = wd;
      sfr_wr = w;
      sfr_rd = !w;
      @(posedge mclk);
      #1 v = sfr_rdata;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      @(posedge mclk);
      #1;
   endtask : acc
   task automatic rdc(input string n, input logic [7:0] a, e);
      acc(1'b0, a, 8'h00);
      chk(n, e, v);
   endtask : rdc
   task automatic sbits(input logic [7:0] b, input int n);
      for (int j = 7; j > 7 - n; j--) begin
         mosi_m = b[j];
         repeat (4) @(posedge mclk);
         #1 sck_m = 1'b1;
         so = {so[6:0], miso_o};
         repeat (4) @(posedge mclk);
         #1 sck_m = 1'b0;
      end
      repeat (8) @(posedge mclk);
      #1;
   endtask : sbits
   task automatic print_verdict;
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict
   always @(posedge mclk) begin
      if (sck_oe && sck_w !== ckq && tog > 0) chk("sck half", half(dv), 8'(gap));
      gap <= (sck_w !== ckq) ? 1 : gap + 1;
      if (sck_oe && sck_w !== ckq) tog <= tog + 1;
      ckq <= sck_w;
   end
   initial begin
      #400000;
      num_errors++;
      print_verdict();
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      int         k;
      logic [7:0] b [3];
      {sfr_wr, sfr_rd, sck_m, mosi_m, arm, slow, cpol, cpha, rst_n} = '0;
      {sfr_addr, sfr_wdata, stx, dv} = '0;
      ss_m = 1'b1;
      void'($urandom(27));
      repeat (5) @(posedge mclk);
      #1 rst_n = 1'b1;
      rdc("cfg reset", spc_pkg::ADDR_CFG, spc_pkg::RST_CFG);
      rdc("ctl reset", spc_pkg::ADDR_CTL, spc_pkg::RST_CTL);
      rdc("div reset", spc_pkg::ADDR_DIV, spc_pkg::RST_DIV);
      rdc("unmapped", 8'h55, 8'h00);
      for (int m = 0; m < 4; m++) begin
         acc(1'b1, spc_pkg::ADDR_CTL, 8'(m << 2));
         chk("ss pins", 8'({m[1], m[1] & m[0]}), {6'h0, ss_oe, ss_o & ss_oe});
      end
      for (int i = 0; i < 6; i++) begin
         cpha = i[1];
         cpol = i[0];
         slow = i[2];
         dv = (i == 0) ? 8'h00 : 8'($urandom_range(3, 1));
         d = 8'($urandom);
         stx = 8'($urandom);
         tog = 0;
         acc(1'b1, spc_pkg::ADDR_CTL, 8'h01);
         acc(1'b1, spc_pkg::ADDR_CFG, {2'b01, cpha, cpol, 4'h0});
         acc(1'b1, spc_pkg::ADDR_DIV, dv);
         rdc("cfg master", spc_pkg::ADDR_CFG, cfg_exp(1'b1, cpha, cpol));
         chk("sck idle", {7'h0, cpol}, {7'h0, sck_w});
         arm = 1'b1;
         tog = 0;
         @(posedge mclk);
         #1 arm = 1'b0;
         acc(1'b1, spc_pkg::ADDR_DAT, d);
         acc(1'b1, spc_pkg::ADDR_DAT, ~d);
         rdc("cfg busy", spc_pkg::ADDR_CFG, cfg_exp(1'b1, cpha, cpol) | 8'h80);
         for (k = 0; k < 200 && v[7] === 1'b1; k++) acc(1'b0, spc_pkg::ADDR_CFG, 8'h00);
         chk("busy end", 8'h00, v & 8'h80);
         chk("sck toggles", 8'h10, 8'(tog));
         rdc("ctl flags", spc_pkg::ADDR_CTL, 8'hC3);
         rdc("master rx", spc_pkg::ADDR_DAT, stx);
         chk("slave rx", d, srx);
         acc(1'b1, spc_pkg::ADDR_CTL, 8'h01);
         rdc("ctl clear", spc_pkg::ADDR_CTL, 8'h03);
      end
      acc(1'b1, spc_pkg::ADDR_CTL, 8'h05);
      ss_m = 1'b0;
      repeat (8) @(posedge mclk);
      #1 rdc("ctl fault", spc_pkg::ADDR_CTL, 8'h26);
      chk("fault event", 8'h01, {7'h0, event_req});
      acc(1'b0, spc_pkg::ADDR_CFG, 8'h00);
      chk("fault master", 8'h00, v & 8'h40);
      acc(1'b1, spc_pkg::ADDR_CFG, 8'h00);
      acc(1'b1, spc_pkg::ADDR_CTL, 8'h05);
      repeat (4) @(posedge mclk);
      #1 rdc("cfg slave", spc_pkg::ADDR_CFG, 8'h0B);
      chk("slave oe", 8'h01, {7'h0, miso_oe});
      sbits(8'($urandom), 3);
      ss_m = 1'b1;
      repeat (6) @(posedge mclk);
      #1 ss_m = 1'b0;
      t = 8'($urandom);
      acc(1'b1, spc_pkg::ADDR_DAT, t);
      for (k = 0; k < 3; k++) begin
         b[k] = 8'($urandom);
         sbits(b[k], 8);
         if (k == 0) chk("slave tx", t, so);
      end
      rdc("ctl overrun", spc_pkg::ADDR_CTL, 8'h97);
      acc(1'b0, spc_pkg::ADDR_CFG, 8'h00);
      chk("rx full", 8'h00, v & 8'h01);
      rdc("slave byte 0", spc_pkg::ADDR_DAT, b[0]);
      rdc("slave byte 1", spc_pkg::ADDR_DAT, b[1]);
      acc(1'b0, spc_pkg::ADDR_CFG, 8'h00);
      chk("rx drained", 8'h01, v & 8'h01);
      acc(1'b1, spc_pkg::ADDR_CTL, 8'h04);
      acc(1'b1, spc_pkg::ADDR_CFG, 8'h40);
      acc(1'b1, spc_pkg::ADDR_DAT, 8'h5A);
      repeat (40) @(posedge mclk);
      #1 chk("disabled oe", 8'h00, {5'h0, sck_oe, mosi_oe, miso_oe});
      print_verdict();
   end
endmodule : tb
`default_nettype wire
